/* jdr_pkg.sv */
// Shared constants and types for the JTAG debug readout block.
// Assumes one 10 MHz core clock; the tile signals arrive synchronous to it.
package jdr_pkg;

    // ************************************************************
    // Instruction codes
    // ************************************************************
    localparam logic [7:0] CODE_PROBE_FIRST = 8'h10;
    localparam logic [7:0] CODE_PROBE_LAST  = 8'h7f;
    localparam logic [7:0] CODE_ROM_READ    = 8'h80;
    localparam logic [7:0] CODE_ROM_ADDR    = 8'h81;
    localparam logic [7:0] CODE_RAM_LOAD    = 8'h82;
    localparam logic [7:0] CODE_PROBE_GROUP = 8'h83;

    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int unsigned PROBE_COUNT      = 112;
    localparam int unsigned PROBE_IDX_W      = 7;
    localparam int unsigned PROBE_GROUP_SIZE = 4;
    localparam int unsigned ROM_PAGES        = 8;
    localparam int unsigned ROM_PAGE_W       = 3;
    localparam int unsigned ROM_WORD_W       = 128;
    localparam int unsigned RAM_AW           = 8;
    localparam int unsigned RAM_DW           = 16;
    localparam int unsigned RAM_WORD_W       = RAM_AW + RAM_DW;

    // Edge choice for the probe sample register
    localparam int unsigned EDGE_NONE = 0;
    localparam int unsigned EDGE_RISE = 1;
    localparam int unsigned EDGE_FALL = 2;

    // ************************************************************
    // Register map and fields
    // ************************************************************
    localparam logic [7:0]  REG_CTRL       = 8'h00;
    localparam logic [7:0]  REG_STATUS     = 8'h04;
    localparam logic [7:0]  REG_RAM_ADDR   = 8'h08;
    localparam logic [7:0]  REG_RAM_DATA   = 8'h0c;
    localparam int unsigned CTRL_SRC_BIT   = 0;
    localparam int unsigned CTRL_AUTO_BIT  = 1;
    localparam int unsigned CTRL_PAGE_LSB  = 8;
    localparam int unsigned CTRL_BASE_LSB  = 16;
    localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
    localparam logic [31:0] CTRL_MASK      = 32'h007f_0703;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {ST_IDLE, ST_CAPTURE, ST_SHIFT, ST_UPDATE} jdr_dr_state_type;

    typedef struct packed {
        logic shift;
        logic capture;
        logic update;
    } jdr_dr_flags_type;

    typedef struct packed {
        logic [7:0] addr;
        logic       write;
        logic       valid;
    } jdr_ahb_req_type;

endpackage : jdr_pkg

/* jdr_init_ram.sv */
// Small SRAM that the host can preload through the test port.
// Assumes one write port on the core clock and a registered read port.
`timescale 1ns/1ns
module jdr_init_ram import jdr_pkg::*; #(
    parameter int unsigned AW = RAM_AW,
    parameter int unsigned DW = RAM_DW
) (
    // Clock and reset
    input  wire logic          clock,
    input  wire logic          reset_n,
    // Write port
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    // Read port
    input  wire logic [AW-1:0] rd_addr,
    output logic      [DW-1:0] rd_data
);

    logic [DW-1:0] mem [0:(1<<AW)-1];
    logic [DW-1:0] rd_data_q;

    // Array has no reset; contents are undefined until loaded
    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Read data always from a flop
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rd_data_q <= '0;
        end else begin
            rd_data_q <= mem[rd_addr];
        end
    end

    assign rd_data = rd_data_q;

endmodule : jdr_init_ram

/* jdr_probe_mux.sv */
// Debug multiplexer: picks one internal net, or walks a small group of them.
// Assumes test clock edges arrive as one-cycle pulses on the core clock.
`timescale 1ns/1ns
module jdr_probe_mux import jdr_pkg::*; #(
    parameter int unsigned NUM_PROBES = PROBE_COUNT,
    parameter int unsigned GROUP_N    = PROBE_GROUP_SIZE,
    parameter int unsigned PROBE_EDGE = EDGE_RISE
) (
    // Clock and reset
    input  wire logic                   clock,
    input  wire logic                   reset_n,
    // Test clock edge pulses
    input  wire logic                   tck_rise,
    input  wire logic                   tck_fall,
    // Nets and selection
    input  wire logic [NUM_PROBES-1:0]  probe_nets,
    input  wire logic [PROBE_IDX_W-1:0] probe_sel,
    input  wire logic                   group_mode,
    input  wire logic [PROBE_IDX_W-1:0] group_base,
    // Result
    output logic                        probe_bit
);

    localparam int unsigned KW = (GROUP_N > 1) ? $clog2(GROUP_N) : 1;

    logic               live;
    logic               samp_q, samp_d;
    logic [GROUP_N-1:0] grp_q, grp_d;
    logic [KW-1:0]      k_q, k_d;
    logic [KW-1:0]      prev_k;

    // Out-of-range index below 128 reads as zero; a group index of 128 or more is cut to 7 bits first and wraps onto net 0 onward
    function automatic logic net_at(input logic [NUM_PROBES-1:0] nets,
                                    input logic [PROBE_IDX_W-1:0] idx);
        net_at = (int'(idx) < NUM_PROBES) ? nets[idx] : 1'b0;
    endfunction : net_at

    // Next values of sampler and group walker
    always_comb begin
        live   = net_at(probe_nets, probe_sel);
        samp_d = samp_q;
        grp_d  = grp_q;
        k_d    = k_q;
        if ((PROBE_EDGE == EDGE_RISE && tck_rise) ||
            (PROBE_EDGE == EDGE_FALL && tck_fall)) begin
            samp_d = live;
        end
        if (!group_mode) begin
            k_d = '0;
        end else if (tck_rise) begin
            // Snapshot whole group so its members line up in time
            if (k_q == '0) begin
                for (int i = 0; i < GROUP_N; i++) begin
                    grp_d[i] = net_at(probe_nets, PROBE_IDX_W'(int'(group_base) + i));
                end
            end
            k_d = (int'(k_q) == GROUP_N - 1) ? '0 : KW'(k_q + 1'b1);
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            samp_q <= 1'b0;
            grp_q  <= '0;
            k_q    <= '0;
        end else begin
            samp_q <= samp_d;
            grp_q  <= grp_d;
            k_q    <= k_d;
        end
    end

    // Show the member just stepped past, so base + 0 leaves first after a snapshot
    assign prev_k    = (k_q == '0) ? KW'(GROUP_N - 1) : KW'(k_q - 1'b1);
    assign probe_bit = group_mode ? grp_q[prev_k] :
                       (PROBE_EDGE == EDGE_NONE) ? live : samp_q;

    a_edge_sample: assert property (@(posedge clock) disable iff (!reset_n)
        (PROBE_EDGE == EDGE_RISE && tck_rise) |=> samp_q == $past(live))
        else $error("probe sample missed rising test clock");

    a_group_step: assert property (@(posedge clock) disable iff (!reset_n)
        (group_mode && tck_rise && int'(k_q) < GROUP_N - 1) |=> k_q == $past(k_q) + 1'b1)
        else $error("group walker did not advance");

endmodule : jdr_probe_mux

/* jdr_readout.sv */
// Core logic behind the user test-port tile: debug net readout, ROM page
// serializer and SRAM preload, with an AHB-Lite register slave.
// Assumes tile signals and the test clock are sampled on the core clock,
// which runs well above the test clock rate.
`timescale 1ns/1ns
module jdr_readout import jdr_pkg::*; #(
    parameter int unsigned NUM_PROBES = PROBE_COUNT,
    parameter int unsigned GROUP_N    = PROBE_GROUP_SIZE,
    parameter int unsigned PROBE_EDGE = EDGE_RISE
) (
    // Clock and reset
    input  wire logic                  clock,
    input  wire logic                  reset_n,
    // AHB-Lite slave
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic      [31:0]           hrdata,
    // Test-port tile
    input  wire logic                  tile_serial_in,
    output logic                       tile_serial_out,
    input  wire logic                  dr_shift_clock,
    input  wire logic                  dr_shift_flag,
    input  wire logic                  dr_capture_flag,
    input  wire logic                  dr_update_flag,
    input  wire logic [7:0]            user_instruction_bits,
    // Nonvolatile ROM, read asynchronously
    output logic      [ROM_PAGE_W-1:0] rom_page,
    input  wire logic [ROM_WORD_W-1:0] rom_word,
    // Internal nets under observation
    input  wire logic [NUM_PROBES-1:0] probe_nets
);

    // ************************************************************
    // Declarations
    // ************************************************************
    logic                    tck_q, tck_rise, tck_fall;
    jdr_dr_flags_type        flags_q, flags_d;
    jdr_dr_state_type        st_q, st_d;
    logic                    enter_update;
    logic                    is_probe, is_group, is_rom_read, is_rom_addr, is_ram_load;
    logic [ROM_WORD_W-1:0]   sr_q, sr_d;
    logic [ROM_PAGE_W-1:0]   addr_sr_q, addr_sr_d;
    logic [ROM_PAGE_W-1:0]   host_page_q, host_page_d;
    logic [ROM_PAGE_W-1:0]   gen_page_q, gen_page_d;
    logic [ROM_PAGE_W-1:0]   rom_page_q, rom_page_d;
    logic [RAM_WORD_W-1:0]   ram_sr_q, ram_sr_d;
    logic [15:0]             ram_writes_q, ram_writes_d;
    logic                    ram_we;
    logic                    out_q, out_d;
    logic                    probe_bit;
    logic [PROBE_IDX_W-1:0]  probe_sel;
    jdr_ahb_req_type         req_q, req_d;
    logic                    rd_pend_q, rd_pend_d;
    logic [31:0]             ctrl_q, ctrl_d;
    logic [RAM_AW-1:0]       ram_addr_q, ram_addr_d;
    logic [31:0]             hrdata_q, hrdata_d;
    logic [RAM_DW-1:0]       ram_rdata;
    logic                    wr_phase;

    // ************************************************************
    // Test clock edges and instruction decode
    // ************************************************************
    // Shift clock is a plain synchronous input, so edges come from one delay flop
    assign tck_rise = dr_shift_clock & ~tck_q;
    assign tck_fall = ~dr_shift_clock & tck_q;

    // Tile refreshes the instruction itself on Update-IR; it is used as given
    assign is_probe    = (user_instruction_bits >= CODE_PROBE_FIRST) &&
                         (user_instruction_bits <= CODE_PROBE_LAST);
    assign is_group    = (user_instruction_bits == CODE_PROBE_GROUP);
    assign is_rom_read = (user_instruction_bits == CODE_ROM_READ);
    assign is_rom_addr = (user_instruction_bits == CODE_ROM_ADDR);
    assign is_ram_load = (user_instruction_bits == CODE_RAM_LOAD);
    assign probe_sel   = PROBE_IDX_W'(user_instruction_bits - CODE_PROBE_FIRST);

    // Debug multiplexer
    jdr_probe_mux #(
        .NUM_PROBES (NUM_PROBES),
        .GROUP_N    (GROUP_N),
        .PROBE_EDGE (PROBE_EDGE)
    ) u_probe_mux (
        .clock      (clock),
        .reset_n    (reset_n),
        .tck_rise   (tck_rise),
        .tck_fall   (tck_fall),
        .probe_nets (probe_nets),
        .probe_sel  (probe_sel),
        .group_mode (is_group),
        .group_base (ctrl_q[CTRL_BASE_LSB +: PROBE_IDX_W]),
        .probe_bit  (probe_bit)
    );

    // ************************************************************
    // Data-register sequencing, serializer, address and SRAM load
    // ************************************************************
    // Flags are registered so the value seen at a test clock rise is the one
    // held during the preceding low half of the test clock
    always_comb begin
        flags_d.shift   = dr_shift_flag;
        flags_d.capture = dr_capture_flag;
        flags_d.update  = dr_update_flag;
        // Phase follows the tile flags, capture taking precedence
        if (flags_q.capture) begin
            st_d = ST_CAPTURE;
        end else if (flags_q.shift) begin
            st_d = ST_SHIFT;
        end else if (flags_q.update) begin
            st_d = ST_UPDATE;
        end else begin
            st_d = ST_IDLE;
        end
        enter_update = (st_d == ST_UPDATE) && (st_q != ST_UPDATE);

        sr_d         = sr_q;
        addr_sr_d    = addr_sr_q;
        host_page_d  = host_page_q;
        gen_page_d   = gen_page_q;
        ram_sr_d     = ram_sr_q;
        ram_writes_d = ram_writes_q;
        ram_we       = 1'b0;

        // ROM serializer: load during capture, shift only in shift phase
        if (is_rom_read && flags_q.capture) begin
            sr_d = rom_word;
        end else if (is_rom_read && flags_q.shift && tck_rise) begin
            sr_d = {tile_serial_in, sr_q[ROM_WORD_W-1:1]};
        end

        // Host-supplied page address
        if (is_rom_addr && flags_q.shift && tck_rise) begin
            addr_sr_d = {tile_serial_in, addr_sr_q[ROM_PAGE_W-1:1]};
        end
        if (is_rom_addr && enter_update) begin
            host_page_d = addr_sr_q;
        end

        // Core page generator: software load wins over auto-increment
        if (wr_phase && req_q.addr == REG_CTRL) begin
            gen_page_d = hwdata[CTRL_PAGE_LSB +: ROM_PAGE_W];
        end else if (is_rom_read && enter_update && ctrl_q[CTRL_AUTO_BIT]) begin
            gen_page_d = ROM_PAGE_W'(gen_page_q + 1'b1);
        end

        // SRAM preload word: address above data, least bit first
        if (is_ram_load && flags_q.shift && tck_rise) begin
            ram_sr_d = {tile_serial_in, ram_sr_q[RAM_WORD_W-1:1]};
        end
        if (is_ram_load && enter_update) begin
            ram_we       = 1'b1;
            ram_writes_d = 16'(ram_writes_q + 1'b1);
        end

        // ROM address source: host by default, core generator on request
        rom_page_d = ctrl_q[CTRL_SRC_BIT] ? gen_page_q : host_page_q;

        // Serial output selection
        if (is_probe || is_group) begin
            out_d = probe_bit;
        end else if (is_rom_read) begin
            out_d = sr_q[0];
        end else if (is_rom_addr) begin
            out_d = addr_sr_q[0];
        end else if (is_ram_load) begin
            out_d = ram_sr_q[0];
        end else begin
            out_d = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            tck_q        <= 1'b0;
            flags_q      <= '0;
            st_q         <= ST_IDLE;
            sr_q         <= '0;
            addr_sr_q    <= '0;
            host_page_q  <= '0;
            gen_page_q   <= '0;
            rom_page_q   <= '0;
            ram_sr_q     <= '0;
            ram_writes_q <= '0;
            out_q        <= 1'b0;
        end else begin
            tck_q        <= dr_shift_clock;
            flags_q      <= flags_d;
            st_q         <= st_d;
            sr_q         <= sr_d;
            addr_sr_q    <= addr_sr_d;
            host_page_q  <= host_page_d;
            gen_page_q   <= gen_page_d;
            rom_page_q   <= rom_page_d;
            ram_sr_q     <= ram_sr_d;
            ram_writes_q <= ram_writes_d;
            out_q        <= out_d;
        end
    end

    assign tile_serial_out = out_q;
    assign rom_page        = rom_page_q;

    // Contents vanish at power loss; host must reload after each power-up
    jdr_init_ram #(
        .AW      (RAM_AW),
        .DW      (RAM_DW)
    ) u_init_ram (
        .clock   (clock),
        .reset_n (reset_n),
        .wr_en   (ram_we),
        .wr_addr (ram_sr_q[RAM_WORD_W-1 -: RAM_AW]),
        .wr_data (ram_sr_q[RAM_DW-1:0]),
        .rd_addr (ram_addr_d),
        .rd_data (ram_rdata)
    );

    // ************************************************************
    // AHB-Lite register slave
    // ************************************************************
    // Writes finish with no wait; reads take one wait so hrdata is a flop
    always_comb begin
        req_d.valid = hsel && hready && htrans[1];
        req_d.write = hwrite;
        req_d.addr  = haddr[7:0];
        rd_pend_d   = req_d.valid && !hwrite;
        wr_phase    = req_q.valid && req_q.write;
        ctrl_d      = ctrl_q;
        ram_addr_d  = ram_addr_q;
        hrdata_d    = hrdata_q;
        if (wr_phase && req_q.addr == REG_CTRL) begin
            ctrl_d = hwdata & CTRL_MASK;
        end
        // Read port follows the new address at once, so no stale readback
        if (wr_phase && req_q.addr == REG_RAM_ADDR) begin
            ram_addr_d = hwdata[RAM_AW-1:0];
        end
        if (rd_pend_q) begin
            unique case (req_q.addr)
                REG_CTRL:     hrdata_d = ctrl_q;
                REG_STATUS:   hrdata_d = {ram_writes_q, 5'h00, rom_page_q,
                                          user_instruction_bits};
                REG_RAM_ADDR: hrdata_d = {{(32-RAM_AW){1'b0}}, ram_addr_q};
                REG_RAM_DATA: hrdata_d = {{(32-RAM_DW){1'b0}}, ram_rdata};
                default:      hrdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            req_q      <= '0;
            rd_pend_q  <= 1'b0;
            ctrl_q     <= CTRL_RESET;
            ram_addr_q <= '0;
            hrdata_q   <= '0;
        end else begin
            req_q      <= req_d;
            rd_pend_q  <= rd_pend_d;
            ctrl_q     <= ctrl_d;
            ram_addr_q <= ram_addr_d;
            hrdata_q   <= hrdata_d;
        end
    end

    assign hreadyout = ~rd_pend_q;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    a_capture_load: assert property (
        (is_rom_read && flags_q.capture) |=> sr_q == $past(rom_word))
        else $error("ROM word not loaded during capture");

    a_shift_step: assert property (
        (is_rom_read && !flags_q.capture && flags_q.shift && tck_rise)
        |=> sr_q[ROM_WORD_W-2:0] == $past(sr_q[ROM_WORD_W-1:1]))
        else $error("serializer did not shift by one bit");

    a_shift_hold: assert property (
        !(is_rom_read && (flags_q.capture || (flags_q.shift && tck_rise)))
        |=> $stable(sr_q))
        else $error("serializer moved outside shift phase");

    a_rom_serial: assert property (
        is_rom_read |=> tile_serial_out == $past(sr_q[0]))
        else $error("serial out not fed from serializer");

    a_probe_out: assert property (
        (is_probe || is_group) |=> tile_serial_out == $past(probe_bit))
        else $error("serial out not fed from probe mux");

    a_page_source: assert property (
        ctrl_q[CTRL_SRC_BIT] |=> rom_page == $past(gen_page_q))
        else $error("ROM page not from core generator");

    a_host_page: assert property (
        (is_rom_addr && enter_update) ##1 !ctrl_q[CTRL_SRC_BIT]
        |=> rom_page == $past(addr_sr_q, 2))
        else $error("host page not applied");

    a_ram_count: assert property (
        ram_we |=> ram_writes_q == 16'($past(ram_writes_q) + 1'b1))
        else $error("SRAM preload write not counted");

    a_dr_phase: assert property (
        flags_q.shift && !flags_q.capture |=> st_q == ST_SHIFT)
        else $error("phase tracker missed shift");

    a_read_wait: assert property (
        (hsel && hready && htrans[1] && !hwrite) |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");

endmodule : jdr_readout

/* jdr_host.sv */
// Host and tile stand-in: test clock, DR flags, TDI and instruction.
// Assumes the core clock; each test clock half lasts four core cycles.
`timescale 1ns/1ns
module jdr_host import jdr_pkg::*; (
    // Core side
    input  wire logic        clock,
    // Tile side
    output logic             tck = 1'b0,
    output logic             tdi = 1'b0,
    output jdr_dr_flags_type flags = '0,
    output logic [7:0]       instr = 8'h00
);
    // One test clock; flags and code settle well before the rise
    task automatic tick(input jdr_dr_flags_type f, input logic d, input logic [7:0] c);
        flags <= f;
        instr <= c;
        tdi <= d;
        repeat (4) @(posedge clock);
        tck <= 1'b1;
        repeat (2) @(posedge clock);
        tdi <= ~d; // Not held past its use
        repeat (2) @(posedge clock);
        tck <= 1'b0;
    endtask : tick
endmodule : jdr_host

/* testbench.sv */
// Bench for the readout block: register access and test-port scans.
// Assumes the host model on the tile side; ROM modelled inline.
`timescale 1ns/1ns
module testbench import jdr_pkg::*;;
    localparam jdr_dr_flags_type CAP = 3'b010, SH = 3'b100, UPD = 3'b001, NO = 3'b000;
    logic clock = 1'b0, reset_n = 1'b0, hwrite = 1'b0, hrdy, hresp, so, tck, tdi;
    logic [1:0] htrans = 2'h0;
    logic [2:0] page;
    logic [7:0] instr, code = 8'h00;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [111:0] pn = '0;
    jdr_dr_flags_type fl;
    int n_fail = 0, samples_checked = 0, k, codes[5] = '{15, 16, 17, 64, 127};
    always #50 clock = ~clock;
    jdr_host i_jdr_host (.clock(clock), .tck(tck), .tdi(tdi), .flags(fl), .instr(instr));
    jdr_readout i_jdr_readout (.clock(clock), .reset_n(reset_n), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy),
        .hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata), .tile_serial_in(tdi),
        .tile_serial_out(so), .dr_shift_clock(tck), .dr_shift_flag(fl.shift),
        .dr_capture_flag(fl.capture), .dr_update_flag(fl.update),
        .user_instruction_bits(instr), .rom_page(page),
        .rom_word({16{8'ha5 ^ {5'h00, page}}}), .probe_nets(pn));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        n_fail += int'(got !== exp);
        if (got !== exp) $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    endtask : check
    task automatic end_of_test(input int hang);
        n_fail += hang;
        if (n_fail == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test
    task automatic wait_ready;
        k = 0;
        @(posedge clock);
        while (hrdy !== 1'b1 && k < 50) begin
            k++;
            @(posedge clock);
        end
        if (hrdy !== 1'b1) end_of_test(1);
        else rd = hrdata;
    endtask : wait_ready
    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
    endtask : xfer
    task automatic t(input jdr_dr_flags_type f, input logic d);
        i_jdr_host.tick(f, d, code);
    endtask : t
    task automatic scan(input int n, input logic [23:0] d);
        t(CAP, 1'b0);
        for (int i = 0; i < n; i++) t(SH, d[i]);
        t(NO, 1'b0);
        t(UPD, 1'b0);
    endtask : scan
    initial begin
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        for (int j = 0; j < 10; j++) begin
            pn <= {56{j[0], ~j[0]}};
            code = 8'(codes[j / 2]);
            t(NO, 1'b0);
            check(so, code < 16 ? 1'b0 : pn[code - 16]);
        end
        code = 8'h81;
        scan(3, 24'h5);
        check(page, 3'h5);
        code = 8'h80;
        t(CAP, 1'b0);
        t(NO, 1'b0);
        for (int i = 0; i < 8; i++) begin
            check(so, (8'ha0 >> i) & 1);
            t(SH, 1'b0);
        end
        xfer(REG_STATUS, 1'b0, '0);
        check(rd[10:0], 11'h580);
        check(hresp, 1'b0);
        xfer(REG_CTRL, 1'b1, 32'h701);
        xfer(REG_CTRL, 1'b0, '0);
        check(rd, 32'h701);
        check(page, 3'h7);
        xfer(32'h10, 1'b0, '0);
        check(rd, 32'h0);
        code = CODE_RAM_LOAD;
        scan(24, 24'h3c_beef);
        xfer(REG_RAM_ADDR, 1'b1, 32'h3c);
        xfer(REG_RAM_DATA, 1'b0, '0);
        check(rd, 32'hbeef);
        xfer(REG_STATUS, 1'b0, '0);
        check(rd[31:16], 16'h0001);
        // Grouped nets: snapshot at first and fifth rise, changes in between must not show
        xfer(REG_CTRL, 1'b1, 32'h0020_0703);
        pn <= 112'hd << 32;
        code = CODE_PROBE_GROUP;
        for (int i = 0; i < 5; i++) begin
            t(NO, 1'b0);
            pn <= '0;
            check(so, (5'h0d >> i) & 1);
        end
        // Auto-increment wraps the core page after a ROM read scan
        code = CODE_ROM_READ;
        scan(8, 24'h0);
        check(page, 3'h0);
        end_of_test(0);
    end
endmodule : testbench
